// ===== rtl/cas_pkg.sv
package cas_pkg;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_CHARGE_CURRENT = 8'h12;
  localparam logic [7:0] OFS_INPUT_CURRENT = 8'h13;
  localparam logic [7:0] OFS_POWER_STATUS = 8'h14;
  localparam logic [7:0] OFS_LIMIT_MASK = 8'h15;
  localparam logic [7:0] OFS_ZONE_CONFIG = 8'h16;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // Field positions
  localparam int LIMIT_W = 6;
  localparam int STAT_VIN_BIT = 7;
  localparam int STAT_CURR_BIT = 6;
  localparam int MASK_ADAPT_BIT = 7;
  localparam int MASK_VIN_BIT = 6;
  localparam int MASK_CURR_BIT = 5;
  localparam int ZC_VSET_BIT = 7;
  localparam int ZC_ISET_BIT = 6;
  localparam int ZC_HOT_BIT = 5;
  localparam int ZC_WARM_LSB = 3;
  localparam int ZC_COOL_LSB = 1;
  localparam int ZC_COLD_BIT = 0;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] ADC_RST = 8'h00;
  localparam logic [5:0] LIMIT_RST = 6'h08;
  localparam logic [1:0] MASK_EN_RST = 2'h3;
  localparam logic [7:0] ZONE_CONFIG_RST = 8'hEE;

  // ==========================================================
  // Scale factors, tenths of mA
  localparam int CHARGE_LSB_TENTH_MA = 175;
  localparam int INPUT_LSB_TENTH_MA = 133;
  localparam int LIMIT_LSB_TENTH_MA = 500;
  localparam int LIMIT_OFFSET_TENTH_MA = 1000;

  // ==========================================================
  // Zone settings, mV, per mille and tenths of a percent
  localparam logic [7:0] ZONE_DROP_SMALL_MV = 8'h64;
  localparam logic [7:0] ZONE_DROP_LARGE_MV = 8'hC8;
  localparam logic [9:0] ZONE_SCALE_HALF = 10'h1F4;
  localparam logic [9:0] ZONE_SCALE_SIXTH = 10'h0A7;
  localparam logic [9:0] PCT_34_0 = 10'h154;
  localparam logic [9:0] PCT_36_0 = 10'h168;
  localparam logic [9:0] PCT_38_0 = 10'h17C;
  localparam logic [9:0] PCT_40_0 = 10'h190;
  localparam logic [9:0] PCT_43_0 = 10'h1AE;
  localparam logic [9:0] PCT_60_0 = 10'h258;
  localparam logic [9:0] PCT_64_0 = 10'h280;
  localparam logic [9:0] PCT_68_0 = 10'h2A8;
  localparam logic [9:0] PCT_72_0 = 10'h2D0;

endpackage

// ===== rtl/cas_sync.sv
`timescale 1ns/10ps
module cas_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // ==========================================================
  // Two stages; only the second stage is visible
  always_comb begin
    meta_nxt = meta_r;
    q_nxt = q_r;
    if (ce) begin
      meta_nxt = d;
      q_nxt = meta_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// ===== rtl/cas_scale.sv
`timescale 1ns/10ps
module cas_scale #(
  parameter int IN_W = 8,
  parameter int OUT_W = 16,
  parameter int WEIGHT = 1,
  parameter int OFFSET = 0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [IN_W-1:0] code,
  output logic [OUT_W-1:0] value
);

  localparam logic [OUT_W-1:0] WEIGHT_W = OUT_W'(WEIGHT);
  localparam logic [OUT_W-1:0] OFFSET_W = OUT_W'(OFFSET);

  logic [OUT_W-1:0] value_r;
  logic [OUT_W-1:0] value_nxt;

  // ==========================================================
  // Binary weighted code to engineering units
  always_comb begin
    value_nxt = value_r;
    if (ce) begin
      value_nxt = OUT_W'(OUT_W'(code) * WEIGHT_W + OFFSET_W);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value_r <= OFFSET_W;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;

endmodule

// ===== rtl/cas_regs.sv
`timescale 1ns/10ps
// Overview of operation
// RULE_01: Charge current reads 8 bits, 17.5mA LSB.
// RULE_02: Input current reads 8 bits, 13.3mA LSB.
// RULE_03: Input limit field: 50mA steps plus 100mA.
// RULE_04: Status bits 7/6 show voltage/current limiting.
// RULE_05: Mask bit 7 shows adaptive current action.
// RULE_06: Interrupt asserts per limit when enable set.
// RULE_07: Zone bits pick voltage drop, current scale.
// RULE_08: Bit 5 selects hot threshold 34/36%.
// RULE_09: Bits 4:3 select warm threshold.
// RULE_10: Bits 2:1 select cool threshold.
// RULE_11: Bit 0 selects cold threshold 72/68%.
// RULE_12: Read-only bits ignore writes; reads harmless.
module cas_regs (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic REG_RESET,
  input wire logic WATCHDOG_EXPIRY,
  input wire logic [7:0] CHARGE_CURRENT_READING,
  input wire logic [7:0] INPUT_CURRENT_READING,
  input wire logic INPUT_VOLTAGE_LIMIT_FLAG,
  input wire logic INPUT_CURRENT_LIMIT_FLAG,
  input wire logic [5:0] EFFECTIVE_INPUT_LIMIT,
  input wire logic ADAPTIVE_CURRENT_FLAG,
  output logic LIMIT_IRQ_N,
  output logic [7:0] ZONE_VOLTAGE_REDUCTION_MV,
  output logic [9:0] ZONE_CURRENT_SCALE_PERMIL,
  output logic [9:0] HOT_THRESHOLD_PCT10,
  output logic [9:0] WARM_THRESHOLD_PCT10,
  output logic [9:0] COOL_THRESHOLD_PCT10,
  output logic [9:0] COLD_THRESHOLD_PCT10,
  output logic [15:0] CHARGE_CURRENT_TENTH_MA,
  output logic [15:0] INPUT_CURRENT_TENTH_MA,
  output logic [15:0] INPUT_LIMIT_TENTH_MA
);

  localparam int SYNC_W = 25;

  // ==========================================================
  // Threshold decoding
  function automatic logic [9:0] cool_pct(input logic [1:0] sel);
    logic [9:0] pct;
    case (sel)
      2'h0: pct = cas_pkg::PCT_72_0;
      2'h1: pct = cas_pkg::PCT_68_0;
      2'h2: pct = cas_pkg::PCT_64_0;
      default: pct = cas_pkg::PCT_60_0;
    endcase
    return pct;
  endfunction

  function automatic logic [9:0] warm_pct(input logic [1:0] sel);
    logic [9:0] pct;
    case (sel)
      2'h0: pct = cas_pkg::PCT_43_0;
      2'h1: pct = cas_pkg::PCT_40_0;
      2'h2: pct = cas_pkg::PCT_38_0;
      default: pct = cas_pkg::PCT_36_0;
    endcase
    return pct;
  endfunction

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // ==========================================================
  // Analogue side inputs
  logic [SYNC_W-1:0] raw_in, sync_q;
  logic [SYNC_W-1:0] prev_r, prev_nxt;
  logic [1:0] fill_r, fill_nxt;
  logic stable;

  assign raw_in = {CHARGE_CURRENT_READING, INPUT_CURRENT_READING, INPUT_VOLTAGE_LIMIT_FLAG,
                   INPUT_CURRENT_LIMIT_FLAG, EFFECTIVE_INPUT_LIMIT, ADAPTIVE_CURRENT_FLAG};

  cas_sync #(.W(SYNC_W)) u_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .d(raw_in),
    .q(sync_q)
  );

  // Multi-bit words may be caught mid-change, so only a sample that repeats on two edges is taken
  assign stable = (sync_q == prev_r);

  // ==========================================================
  // Register state
  logic [7:0] charge_r, charge_nxt;
  logic [7:0] input_r, input_nxt;
  logic vin_flag_r, vin_flag_nxt;
  logic curr_flag_r, curr_flag_nxt;
  logic [5:0] limit_r, limit_nxt;
  logic adapt_r, adapt_nxt;
  logic vin_en_r, vin_en_nxt;
  logic curr_en_r, curr_en_nxt;
  logic [7:0] zone_r, zone_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic irq_n_r, irq_n_nxt;
  logic soft_rst;
  logic [7:0] power_status;
  logic [7:0] mask_view;

  assign soft_rst = REG_RESET | WATCHDOG_EXPIRY;

  // RULE_04 status layout
  assign power_status = {vin_flag_r, curr_flag_r, limit_r};
  // RULE_05 adaptive flag view
  assign mask_view = {adapt_r, vin_en_r, curr_en_r, 5'h00};

  always_comb begin
    prev_nxt = prev_r;
    fill_nxt = fill_r;
    charge_nxt = charge_r;
    input_nxt = input_r;
    vin_flag_nxt = vin_flag_r;
    curr_flag_nxt = curr_flag_r;
    limit_nxt = limit_r;
    adapt_nxt = adapt_r;
    if (CE) begin
      prev_nxt = sync_q;
      fill_nxt = {fill_r[0], 1'b1};
      // Cleared synchroniser stages must never pass for a reading
      if (stable && fill_r[1]) begin
        // RULE_01 charge reading
        charge_nxt = sync_q[24:17];
        // RULE_02 input reading
        input_nxt = sync_q[16:9];
        // RULE_04 limiting flags
        vin_flag_nxt = sync_q[8];
        curr_flag_nxt = sync_q[7];
        // RULE_03 effective limit
        limit_nxt = sync_q[6:1];
        // RULE_05 adaptive action
        adapt_nxt = sync_q[0];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      prev_r <= '0;
      fill_r <= 2'h0;
      charge_r <= cas_pkg::ADC_RST;
      input_r <= cas_pkg::ADC_RST;
      vin_flag_r <= 1'b0;
      curr_flag_r <= 1'b0;
      limit_r <= cas_pkg::LIMIT_RST;
      adapt_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      fill_r <= fill_nxt;
      charge_r <= charge_nxt;
      input_r <= input_nxt;
      vin_flag_r <= vin_flag_nxt;
      curr_flag_r <= curr_flag_nxt;
      limit_r <= limit_nxt;
      adapt_r <= adapt_nxt;
    end
  end

  // ==========================================================
  // Host writes; soft reset beats a write in the same cycle
  always_comb begin
    vin_en_nxt = vin_en_r;
    curr_en_nxt = curr_en_r;
    zone_nxt = zone_r;
    if (CE) begin
      if (soft_rst) begin
        // RULE_06 enables restored
        vin_en_nxt = cas_pkg::MASK_EN_RST[1];
        curr_en_nxt = cas_pkg::MASK_EN_RST[0];
        zone_nxt = cas_pkg::ZONE_CONFIG_RST;
      end else if (REG_WR) begin
        // RULE_12 only writable bits
        if (addr_hit(REG_ADDR, cas_pkg::OFS_LIMIT_MASK)) begin
          vin_en_nxt = REG_WDATA[cas_pkg::MASK_VIN_BIT];
          curr_en_nxt = REG_WDATA[cas_pkg::MASK_CURR_BIT];
        end
        if (addr_hit(REG_ADDR, cas_pkg::OFS_ZONE_CONFIG)) begin
          zone_nxt = REG_WDATA;
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      vin_en_r <= cas_pkg::MASK_EN_RST[1];
      curr_en_r <= cas_pkg::MASK_EN_RST[0];
      zone_r <= cas_pkg::ZONE_CONFIG_RST;
    end else begin
      vin_en_r <= vin_en_nxt;
      curr_en_r <= curr_en_nxt;
      zone_r <= zone_nxt;
    end
  end

  // ==========================================================
  // Host reads and interrupt
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = rvalid_r;
    irq_n_nxt = irq_n_r;
    if (CE) begin
      rvalid_nxt = REG_RD;
      // RULE_06 gated interrupt
      irq_n_nxt = ~((vin_flag_r & vin_en_r) | (curr_flag_r & curr_en_r));
      if (REG_RD) begin
        // RULE_12 reads have no side effect
        case (REG_ADDR)
          cas_pkg::OFS_CHARGE_CURRENT: rdata_nxt = charge_r;
          cas_pkg::OFS_INPUT_CURRENT: rdata_nxt = input_r;
          cas_pkg::OFS_POWER_STATUS: rdata_nxt = power_status;
          cas_pkg::OFS_LIMIT_MASK: rdata_nxt = mask_view;
          cas_pkg::OFS_ZONE_CONFIG: rdata_nxt = zone_r;
          default: rdata_nxt = cas_pkg::UNMAPPED_READ;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      irq_n_r <= 1'b1;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      irq_n_r <= irq_n_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign REG_RVALID = rvalid_r;
  assign LIMIT_IRQ_N = irq_n_r;

  // ==========================================================
  // Temperature zone settings, registered
  logic [7:0] vdrop_r, vdrop_nxt;
  logic [9:0] iscale_r, iscale_nxt;
  logic [9:0] hot_r, hot_nxt;
  logic [9:0] warm_r, warm_nxt;
  logic [9:0] cool_r, cool_nxt;
  logic [9:0] cold_r, cold_nxt;

  always_comb begin
    vdrop_nxt = vdrop_r;
    iscale_nxt = iscale_r;
    hot_nxt = hot_r;
    warm_nxt = warm_r;
    cool_nxt = cool_r;
    cold_nxt = cold_r;
    if (CE) begin
      // RULE_07 voltage drop and current scale
      vdrop_nxt = zone_r[cas_pkg::ZC_VSET_BIT] ? cas_pkg::ZONE_DROP_LARGE_MV : cas_pkg::ZONE_DROP_SMALL_MV;
      iscale_nxt = zone_r[cas_pkg::ZC_ISET_BIT] ? cas_pkg::ZONE_SCALE_SIXTH : cas_pkg::ZONE_SCALE_HALF;
      // RULE_08 hot threshold
      hot_nxt = zone_r[cas_pkg::ZC_HOT_BIT] ? cas_pkg::PCT_36_0 : cas_pkg::PCT_34_0;
      // RULE_09 warm threshold
      warm_nxt = warm_pct(zone_r[cas_pkg::ZC_WARM_LSB +: 2]);
      // RULE_10 cool threshold
      cool_nxt = cool_pct(zone_r[cas_pkg::ZC_COOL_LSB +: 2]);
      // RULE_11 cold threshold, first two points of cool
      cold_nxt = cool_pct({1'b0, zone_r[cas_pkg::ZC_COLD_BIT]});
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      vdrop_r <= cas_pkg::ZONE_DROP_LARGE_MV;
      iscale_r <= cas_pkg::ZONE_SCALE_SIXTH;
      hot_r <= cas_pkg::PCT_36_0;
      warm_r <= cas_pkg::PCT_40_0;
      cool_r <= cas_pkg::PCT_60_0;
      cold_r <= cas_pkg::PCT_72_0;
    end else begin
      vdrop_r <= vdrop_nxt;
      iscale_r <= iscale_nxt;
      hot_r <= hot_nxt;
      warm_r <= warm_nxt;
      cool_r <= cool_nxt;
      cold_r <= cold_nxt;
    end
  end

  assign ZONE_VOLTAGE_REDUCTION_MV = vdrop_r;
  assign ZONE_CURRENT_SCALE_PERMIL = iscale_r;
  assign HOT_THRESHOLD_PCT10 = hot_r;
  assign WARM_THRESHOLD_PCT10 = warm_r;
  assign COOL_THRESHOLD_PCT10 = cool_r;
  assign COLD_THRESHOLD_PCT10 = cold_r;

  // ==========================================================
  // Readings in tenths of mA
  // RULE_01 charge weight
  cas_scale #(.IN_W(8), .OUT_W(16), .WEIGHT(cas_pkg::CHARGE_LSB_TENTH_MA), .OFFSET(0)) u_charge_scale (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .code(charge_r),
    .value(CHARGE_CURRENT_TENTH_MA)
  );

  // RULE_02 input weight
  cas_scale #(.IN_W(8), .OUT_W(16), .WEIGHT(cas_pkg::INPUT_LSB_TENTH_MA), .OFFSET(0)) u_input_scale (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .code(input_r),
    .value(INPUT_CURRENT_TENTH_MA)
  );

  // RULE_03 limit step and offset
  cas_scale #(.IN_W(cas_pkg::LIMIT_W), .OUT_W(16), .WEIGHT(cas_pkg::LIMIT_LSB_TENTH_MA),
    .OFFSET(cas_pkg::LIMIT_OFFSET_TENTH_MA)) u_limit_scale (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .code(limit_r),
    .value(INPUT_LIMIT_TENTH_MA)
  );

endmodule

// ===== tb/cas_regs_chk.sv
`timescale 1ns/10ps
module cas_regs_chk (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic REG_RESET,
  input wire logic WATCHDOG_EXPIRY,
  input wire logic [7:0] CHARGE_CURRENT_READING,
  input wire logic [7:0] INPUT_CURRENT_READING,
  input wire logic INPUT_VOLTAGE_LIMIT_FLAG,
  input wire logic INPUT_CURRENT_LIMIT_FLAG,
  input wire logic [5:0] EFFECTIVE_INPUT_LIMIT,
  input wire logic LIMIT_IRQ_N,
  input wire logic [7:0] ZONE_VOLTAGE_REDUCTION_MV,
  input wire logic [9:0] HOT_THRESHOLD_PCT10,
  input wire logic [15:0] CHARGE_CURRENT_TENTH_MA,
  input wire logic [15:0] INPUT_CURRENT_TENTH_MA,
  input wire logic [15:0] INPUT_LIMIT_TENTH_MA
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // A soft reset in the same cycle wins, so it is left out
  sequence s_zone_wr;
    CE && REG_WR && !REG_RESET && !WATCHDOG_EXPIRY && REG_ADDR == 8'h16 ##1 CE;
  endsequence
  sequence s_no_limit;
    (CE && !INPUT_VOLTAGE_LIMIT_FLAG && !INPUT_CURRENT_LIMIT_FLAG)[*6];
  endsequence

  // ==========================================================
  // Properties
  property p_rd_answer;
    CE |=> REG_RVALID == $past(REG_RD);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer wrong");
  property p_unmapped;
    CE && REG_RD && (REG_ADDR < 8'h12 || REG_ADDR > 8'h16) |=> REG_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_chg_scale;
    (CE && $stable(CHARGE_CURRENT_READING))[*7] |->
      CHARGE_CURRENT_TENTH_MA == 16'(CHARGE_CURRENT_READING) * 16'h00AF;
  endproperty
  a_chg_scale: assert property (p_chg_scale) else $error("charge current scale wrong");
  property p_incur_scale;
    (CE && $stable(INPUT_CURRENT_READING))[*7] |->
      INPUT_CURRENT_TENTH_MA == 16'(INPUT_CURRENT_READING) * 16'h0085;
  endproperty
  a_incur_scale: assert property (p_incur_scale) else $error("input current scale wrong");
  property p_limit_scale;
    (CE && $stable(EFFECTIVE_INPUT_LIMIT))[*7] |->
      INPUT_LIMIT_TENTH_MA == 16'h03E8 + 16'(EFFECTIVE_INPUT_LIMIT) * 16'h01F4;
  endproperty
  a_limit_scale: assert property (p_limit_scale) else $error("input limit scale wrong");
  property p_irq_quiet;
    s_no_limit |-> LIMIT_IRQ_N;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without limiting");
  property p_vred;
    s_zone_wr |=> ZONE_VOLTAGE_REDUCTION_MV == ($past(REG_WDATA[7], 2) ? 8'hC8 : 8'h64);
  endproperty
  a_vred: assert property (p_vred) else $error("voltage reduction wrong");
  property p_hot;
    s_zone_wr |=> HOT_THRESHOLD_PCT10 == ($past(REG_WDATA[5], 2) ? 10'h168 : 10'h154);
  endproperty
  a_hot: assert property (p_hot) else $error("hot threshold wrong");
endmodule

// ===== tb/cas_host.sv
`timescale 1ns/10ps
module cas_host (
  input wire logic clk,
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // Released lines carry the inverse so a stale value cannot pass
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // The answer is registered on the taken edge and sampled at the next falling edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic reg_reset = 1'b0;
  logic wdog = 1'b0;
  logic [7:0] chg = 8'h00;
  logic [7:0] in_cur = 8'h00;
  logic vflag = 1'b0;
  logic iflag = 1'b0;
  logic [5:0] lim = 6'h08;
  logic adapt = 1'b0;
  logic [7:0] addr, wdata, rdata, vred;
  logic wr, rd, rvalid, irq_n;
  logic [9:0] iscale, hot, warm, cool, cold;
  logic [15:0] chg_t, in_cur_t, lim_t;
  logic [65:0] rows [4];
  int n_errors = 0;
  int compares = 0;

  always #12.5 mclk = ~mclk;

  cas_regs u_dut (.MCLK(mclk), .RESETN(resetn), .CE(ce), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_RESET(reg_reset),
    .WATCHDOG_EXPIRY(wdog), .CHARGE_CURRENT_READING(chg), .INPUT_CURRENT_READING(in_cur),
    .INPUT_VOLTAGE_LIMIT_FLAG(vflag), .INPUT_CURRENT_LIMIT_FLAG(iflag), .EFFECTIVE_INPUT_LIMIT(lim),
    .ADAPTIVE_CURRENT_FLAG(adapt), .LIMIT_IRQ_N(irq_n), .ZONE_VOLTAGE_REDUCTION_MV(vred),
    .ZONE_CURRENT_SCALE_PERMIL(iscale), .HOT_THRESHOLD_PCT10(hot), .WARM_THRESHOLD_PCT10(warm),
    .COOL_THRESHOLD_PCT10(cool), .COLD_THRESHOLD_PCT10(cold), .CHARGE_CURRENT_TENTH_MA(chg_t),
    .INPUT_CURRENT_TENTH_MA(in_cur_t), .INPUT_LIMIT_TENTH_MA(lim_t));
  cas_host u_host (.clk(mclk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata),
    .rvalid(rvalid));

  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.read(a, d);
    chk(nm, d, exp);
  endtask
  task automatic conclude;
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rows = '{{8'h00, 8'h64, 10'h1F4, 10'h154, 10'h1AE, 10'h2D0, 10'h2D0},
             {8'hEB, 8'hC8, 10'h0A7, 10'h168, 10'h190, 10'h2A8, 10'h2A8},
             {8'h54, 8'h64, 10'h0A7, 10'h154, 10'h17C, 10'h280, 10'h2D0},
             {8'hBF, 8'hC8, 10'h1F4, 10'h168, 10'h168, 10'h258, 10'h2A8}};
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(negedge mclk);
    chk("irq idle", irq_n, 1'b1);
    rd_chk("chg rst", 8'h12, 8'h00);
    rd_chk("incur rst", 8'h13, 8'h00);
    rd_chk("status rst", 8'h14, 8'h08);
    rd_chk("mask rst", 8'h15, 8'h60);
    rd_chk("zone rst", 8'h16, 8'hEE);
    foreach (rows[i]) begin
      u_host.write(8'h16, rows[i][65:58]);
      repeat (2) @(negedge mclk);
      chk("zone outs", {vred, iscale, hot, warm, cool, cold}, rows[i][57:0]);
      rd_chk("zone reg", 8'h16, rows[i][65:58]);
    end
    // Limiting and readings
    @(posedge mclk);
    chg <= 8'hFF;
    in_cur <= 8'h80;
    lim <= 6'h3F;
    vflag <= 1'b1;
    adapt <= 1'b1;
    repeat (8) @(negedge mclk);
    chk("chg ma", chg_t, 16'hAE51);
    chk("incur ma", in_cur_t, 16'h4280);
    chk("limit ma", lim_t, 16'h7EF4);
    chk("irq v", irq_n, 1'b0);
    rd_chk("chg reg", 8'h12, 8'hFF);
    rd_chk("incur reg", 8'h13, 8'h80);
    rd_chk("status v", 8'h14, 8'hBF);
    u_host.write(8'h14, 8'h00);
    u_host.write(8'h12, 8'h00);
    rd_chk("status ro", 8'h14, 8'hBF);
    rd_chk("chg ro", 8'h12, 8'hFF);
    u_host.write(8'h15, 8'h9F);
    rd_chk("mask", 8'h15, 8'h80);
    repeat (3) @(negedge mclk);
    chk("irq v masked", irq_n, 1'b1);
    @(posedge mclk);
    vflag <= 1'b0;
    iflag <= 1'b1;
    u_host.write(8'h15, 8'h20);
    repeat (6) @(negedge mclk);
    chk("irq i", irq_n, 1'b0);
    rd_chk("status i", 8'h14, 8'h7F);
    u_host.write(8'h15, 8'h40);
    repeat (3) @(negedge mclk);
    chk("irq i masked", irq_n, 1'b1);
    // Soft resets restore the enables and the zone setup
    @(posedge mclk);
    wdog <= 1'b1;
    @(posedge mclk);
    wdog <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("irq wdog", irq_n, 1'b0);
    rd_chk("mask wdog", 8'h15, 8'hE0);
    rd_chk("zone wdog", 8'h16, 8'hEE);
    u_host.write(8'h16, 8'h00);
    @(posedge mclk);
    reg_reset <= 1'b1;
    @(posedge mclk);
    reg_reset <= 1'b0;
    rd_chk("zone regrst", 8'h16, 8'hEE);
    rd_chk("unmapped", 8'h20, 8'h00);
    // Clock enable low: a write must not land
    @(posedge mclk);
    ce <= 1'b0;
    u_host.write(8'h16, 8'h00);
    @(posedge mclk);
    ce <= 1'b1;
    rd_chk("zone frozen", 8'h16, 8'hEE);
    // Reset in mid-run; the limit field must not pass through zero
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk("rst2 outs", {irq_n, vred, iscale, lim_t}, {1'b1, 8'hC8, 10'h0A7, 16'h03E8});
    rd_chk("rst2 status", 8'h14, 8'h08);
    repeat (8) @(negedge mclk);
    chk("rst2 irq", irq_n, 1'b0);
    conclude();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    conclude();
  end
endmodule

bind cas_regs cas_regs_chk u_chk (.MCLK, .RESETN, .CE, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA,
  .REG_RDATA, .REG_RVALID, .REG_RESET, .WATCHDOG_EXPIRY, .CHARGE_CURRENT_READING,
  .INPUT_CURRENT_READING, .INPUT_VOLTAGE_LIMIT_FLAG, .INPUT_CURRENT_LIMIT_FLAG,
  .EFFECTIVE_INPUT_LIMIT, .LIMIT_IRQ_N, .ZONE_VOLTAGE_REDUCTION_MV, .HOT_THRESHOLD_PCT10,
  .CHARGE_CURRENT_TENTH_MA, .INPUT_CURRENT_TENTH_MA, .INPUT_LIMIT_TENTH_MA);
